/* File: design/shp_host_port.sv */
// host port and upper register bank of the synthesizer, parallel or serial
module shp_host_port (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_port_select,
   input wire logic [5:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic i_write_strobe_n,
   input wire logic i_read_strobe_n,
   input wire logic i_register_update_strobe,
   input wire logic i_reference_clock_input,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_serial_data_io,
   output logic o_serial_data_io_oe,
   output logic o_serial_data_out_pin,
   output logic o_serial_data_out_pin_oe,
   output shp_pkg::shp_bank_t o_active_bank
);
   import shp_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   logic [18:0] raw_pins;
   logic [18:0] sync_pins;
   logic par_mode, wr_n_s, rd_n_s, upd_s, ref_s;
   logic [5:0] addr_s;
   logic [7:0] data_s;
   logic ser_mode, sclk_s, cs_n_s, io_rst_s, sdi_s;

   assign raw_pins = {i_port_select, i_addr, i_data, i_write_strobe_n, i_read_strobe_n,
      i_register_update_strobe, i_reference_clock_input};

   // write and read strobes rest high so release of reset makes no false edge
   shp_sync #(.W(19), .RST_VAL(19'h0000c)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_async(raw_pins),
      .o_sync(sync_pins)
   );

   assign {par_mode, addr_s, data_s, wr_n_s, rd_n_s, upd_s, ref_s} = sync_pins;
   assign ser_mode = !par_mode;
   assign sclk_s = wr_n_s;
   assign cs_n_s = rd_n_s;
   assign io_rst_s = addr_s[2];
   assign sdi_s = addr_s[0];

   // ----------------------------------------------------------------
   // edge history
   // ----------------------------------------------------------------
   logic prev_wr, prev_upd, prev_ref, ref_started;
   logic next_prev_wr, next_prev_upd, next_prev_ref, next_ref_started;
   logic ref_first;

   assign ref_first = ref_s && !prev_ref && !ref_started;

   always_comb begin
      next_prev_wr = wr_n_s;
      next_prev_upd = upd_s;
      next_prev_ref = ref_s;
      next_ref_started = ref_started || ref_first;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         prev_wr <= 1'b1;
         prev_upd <= 1'b0;
         prev_ref <= 1'b0;
         ref_started <= 1'b0;
      end else begin
         prev_wr <= next_prev_wr;
         prev_upd <= next_prev_upd;
         prev_ref <= next_prev_ref;
         ref_started <= next_ref_started;
      end
   end

   // ----------------------------------------------------------------
   // register banks
   // ----------------------------------------------------------------
   shp_bank_t staging, next_staging;
   shp_bank_t active, next_active;
   logic [9:0] int_cnt, next_int_cnt;
   logic ext_mode, upd_evt, wr_en, par_wr, ser_wr;
   logic [5:0] wr_addr, par_addr, next_par_addr, ser_ptr, next_ser_ptr;
   logic [7:0] wr_byte, par_data, next_par_data;
   shp_ser_if ser_bus ();

   function automatic logic [7:0] read_byte(input logic [5:0] a, input shp_bank_t b);
      return shp_in_range(a) ? b[shp_idx(a)] : 8'h00;
   endfunction

   // internal mode updates on a free timer, external on the strobe pin
   assign ext_mode = !active[SHP_IDX_MODE][SHP_UPD_INTERNAL_BIT];
   assign upd_evt = (ext_mode && upd_s && !prev_upd) || (!ext_mode && int_cnt == 10'h000)
      || ref_first;

   // parallel write lands on the rising edge of the write strobe
   assign par_wr = par_mode && wr_n_s && !prev_wr;
   assign wr_en = par_wr || ser_wr;
   assign wr_addr = par_mode ? par_addr : ser_ptr;
   assign wr_byte = par_mode ? par_data : ser_bus.rx_byte;

   always_comb begin
      next_par_addr = par_addr;
      next_par_data = par_data;
      if (par_mode && !wr_n_s) begin
         next_par_addr = addr_s;
         next_par_data = data_s;
      end
      next_staging = staging;
      // ignored and reserved bits are never stored, so they read as zero
      if (wr_en && shp_in_range(wr_addr)) begin
         next_staging[shp_idx(wr_addr)] = wr_byte & SHP_MASK_BANK[shp_idx(wr_addr)];
      end
      next_active = upd_evt ? staging : active;
      next_int_cnt = (int_cnt == 10'h000) ? SHP_INT_UPD_CYCLES - 10'h001 : int_cnt - 10'h001;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         par_addr <= 6'h00;
         par_data <= 8'h00;
         staging <= SHP_RESET_BANK;
         active <= SHP_RESET_BANK;
         int_cnt <= SHP_INT_UPD_CYCLES - 10'h001;
      end else begin
         par_addr <= next_par_addr;
         par_data <= next_par_data;
         staging <= next_staging;
         active <= next_active;
         int_cnt <= next_int_cnt;
      end
   end

   // ----------------------------------------------------------------
   // serial controller
   // ----------------------------------------------------------------
   shp_ser_state_t ser_state, next_ser_state;
   logic ser_read, next_ser_read;
   logic [2:0] ser_left, next_ser_left;
   logic lsb_first, sdo_active, ser_abort, ser_tx_phase;
   logic [5:0] start;
   logic [2:0] cnt;

   shp_ser_shift u_shift (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .bus(ser_bus)
   );

   assign lsb_first = active[SHP_IDX_KEY_SER][SHP_LSB_FIRST_BIT];
   assign sdo_active = active[SHP_IDX_KEY_SER][SHP_SDO_ACTIVE_BIT];
   assign ser_abort = par_mode || io_rst_s;
   // chip select high suspends the cycle: edges are simply not seen
   assign ser_bus.rise = ser_mode && !cs_n_s && !io_rst_s && sclk_s && !prev_wr;
   assign ser_bus.fall = ser_mode && !cs_n_s && !io_rst_s && !sclk_s && prev_wr;
   assign ser_bus.sdi = sdi_s;
   assign ser_bus.lsb_first = lsb_first;
   assign ser_bus.abort = ser_abort;
   assign ser_tx_phase = ser_mode && !cs_n_s && ser_state == SHP_SER_DATA && ser_read;

   always_comb begin
      next_ser_state = ser_state;
      next_ser_read = ser_read;
      next_ser_left = ser_left;
      next_ser_ptr = ser_ptr;
      ser_wr = 1'b0;
      ser_bus.tx_load = 1'b0;
      ser_bus.tx_load_byte = 8'h00;
      start = shp_ser_first(ser_bus.rx_byte[3:0]);
      cnt = shp_ser_count(ser_bus.rx_byte[3:0]);
      if (ser_abort) begin
         next_ser_state = SHP_SER_INSTR;
      end else if (ser_bus.byte_done) begin
         unique case (ser_state)
            SHP_SER_INSTR: begin
               next_ser_read = ser_bus.rx_byte[SHP_INSTR_READ_BIT];
               next_ser_left = cnt;
               // least significant byte first walks the register downward
               next_ser_ptr = lsb_first ? start + 6'(cnt) - 6'h01 : start;
               next_ser_state = SHP_SER_DATA;
               ser_bus.tx_load = ser_bus.rx_byte[SHP_INSTR_READ_BIT];
               ser_bus.tx_load_byte = read_byte(next_ser_ptr, staging);
            end
            SHP_SER_DATA: begin
               ser_wr = !ser_read;
               next_ser_ptr = lsb_first ? ser_ptr - 6'h01 : ser_ptr + 6'h01;
               next_ser_left = ser_left - 3'h1;
               if (ser_left == 3'h1) begin
                  next_ser_state = SHP_SER_INSTR;
               end else begin
                  ser_bus.tx_load = ser_read;
                  ser_bus.tx_load_byte = read_byte(next_ser_ptr, staging);
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ser_state <= SHP_SER_INSTR;
         ser_read <= 1'b0;
         ser_left <= 3'h0;
         ser_ptr <= 6'h00;
      end else begin
         ser_state <= next_ser_state;
         ser_read <= next_ser_read;
         ser_left <= next_ser_left;
         ser_ptr <= next_ser_ptr;
      end
   end

   // ----------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------
   logic [7:0] next_data;
   logic next_data_oe, next_sdio, next_sdio_oe, next_sdo, next_sdo_oe;

   always_comb begin
      next_data = read_byte(addr_s, staging);
      next_data_oe = par_mode && !rd_n_s;
      next_sdio = ser_bus.tx_bit;
      next_sdio_oe = ser_tx_phase && !sdo_active;
      next_sdo = ser_bus.tx_bit;
      next_sdo_oe = ser_tx_phase && sdo_active;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
         o_serial_data_io <= 1'b0;
         o_serial_data_io_oe <= 1'b0;
         o_serial_data_out_pin <= 1'b0;
         o_serial_data_out_pin_oe <= 1'b0;
      end else begin
         o_data <= next_data;
         o_data_oe <= next_data_oe;
         o_serial_data_io <= next_sdio;
         o_serial_data_io_oe <= next_sdio_oe;
         o_serial_data_out_pin <= next_sdo;
         o_serial_data_out_pin_oe <= next_sdo_oe;
      end
   end

   assign o_active_bank = active;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   AST_PAR_READ_OE: assert property (par_mode && !rd_n_s |=> o_data_oe)
      else $error("parallel read not driven");
   AST_SER_QUIET: assert property (!par_mode |=> !o_data_oe)
      else $error("data bus driven in serial mode");
   AST_PAR_WRITE: assert property (par_wr && shp_in_range(par_addr) |=>
      staging[shp_idx($past(par_addr))] ==
      ($past(par_data) & SHP_MASK_BANK[shp_idx($past(par_addr))]))
      else $error("parallel write not staged");
   AST_UPDATE_COPY: assert property (upd_evt |=> active == $past(staging))
      else $error("update did not copy staging");
   AST_NO_STRAY_UPDATE: assert property (!upd_evt |=> $stable(active))
      else $error("active bank changed without update");
   AST_REF_START: assert property (ref_first |=> active == $past(staging))
      else $error("reference start did not load bank");
   AST_ABORT: assert property (io_rst_s |=>
      ser_state == SHP_SER_INSTR ##1 !o_serial_data_io_oe)
      else $error("sync reset did not abort cycle");
   AST_SDO_HIZ: assert property (!sdo_active |=> !o_serial_data_out_pin_oe)
      else $error("separate output driven in one-wire mode");
   AST_SDIO_HIZ: assert property (sdo_active |=> !o_serial_data_io_oe)
      else $error("data pin driven in separate output mode");
   AST_GAIN_MASK: assert property (staging[SHP_IDX_I_GAIN_HI][7:4] == 4'h0 &&
      staging[SHP_IDX_Q_GAIN_HI][7:4] == 4'h0)
      else $error("ignored gain bits stored");
   AST_READ_DATA: assert property (par_mode && !rd_n_s |=>
      o_data == read_byte($past(addr_s), $past(staging)))
      else $error("wrong readback byte");
endmodule // shp_host_port

/* File: design/shp_pkg.sv */
// shared constants, types and decode helpers for the synth host port
package shp_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int SHP_NBYTES = 14;
   localparam logic [5:0] SHP_RAMP_CLK_HI_ADDR = 6'h1a;
   localparam logic [5:0] SHP_RAMP_CLK_MID_ADDR = 6'h1b;
   localparam logic [5:0] SHP_RAMP_CLK_LO_ADDR = 6'h1c;
   localparam logic [5:0] SHP_POWER_DOWN_ADDR = 6'h1d;
   localparam logic [5:0] SHP_REF_MULT_ADDR = 6'h1e;
   localparam logic [5:0] SHP_MODE_ADDR = 6'h1f;
   localparam logic [5:0] SHP_KEY_SER_ADDR = 6'h20;
   localparam logic [5:0] SHP_I_GAIN_HI_ADDR = 6'h21;
   localparam logic [5:0] SHP_I_GAIN_LO_ADDR = 6'h22;
   localparam logic [5:0] SHP_Q_GAIN_HI_ADDR = 6'h23;
   localparam logic [5:0] SHP_Q_GAIN_LO_ADDR = 6'h24;
   localparam logic [5:0] SHP_KEY_RAMP_ADDR = 6'h25;
   localparam logic [5:0] SHP_AUX_DAC_HI_ADDR = 6'h26;
   localparam logic [5:0] SHP_AUX_DAC_LO_ADDR = 6'h27;
   localparam int SHP_IDX_MODE = SHP_MODE_ADDR - SHP_RAMP_CLK_HI_ADDR;
   localparam int SHP_IDX_KEY_SER = SHP_KEY_SER_ADDR - SHP_RAMP_CLK_HI_ADDR;
   localparam int SHP_IDX_I_GAIN_HI = SHP_I_GAIN_HI_ADDR - SHP_RAMP_CLK_HI_ADDR;
   localparam int SHP_IDX_Q_GAIN_HI = SHP_Q_GAIN_HI_ADDR - SHP_RAMP_CLK_HI_ADDR;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SHP_UPD_INTERNAL_BIT = 0;
   localparam int SHP_SDO_ACTIVE_BIT = 0;
   localparam int SHP_LSB_FIRST_BIT = 1;
   localparam int SHP_INSTR_READ_BIT = 7;

   // byte 0 of the bank is the lowest address
   typedef logic [SHP_NBYTES-1:0][7:0] shp_bank_t;
   localparam shp_bank_t SHP_RESET_BANK = {8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h20, 8'h01, 8'h64, 8'h10, 8'h00, 8'h00, 8'h00};
   localparam shp_bank_t SHP_MASK_BANK = {8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f,
      8'h73, 8'hff, 8'h7f, 8'h17, 8'hff, 8'hff, 8'h0f};

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SHP_CLK_PS = 4000;
   localparam int SHP_T_WRITE_PS = 10500;
   localparam int SHP_WRITE_CYCLES = (SHP_T_WRITE_PS + SHP_CLK_PS - 1) / SHP_CLK_PS;
   localparam logic [9:0] SHP_INT_UPD_CYCLES = 10'h3e8;

   typedef enum logic {SHP_SER_INSTR, SHP_SER_DATA} shp_ser_state_t;

   function automatic logic shp_in_range(input logic [5:0] a);
      return (a >= SHP_RAMP_CLK_HI_ADDR) && (a <= SHP_AUX_DAC_LO_ADDR);
   endfunction

   function automatic logic [3:0] shp_idx(input logic [5:0] a);
      logic [5:0] d;
      d = a - SHP_RAMP_CLK_HI_ADDR;
      return d[3:0];
   endfunction

   // first byte address of a serial register; 6'h00 for registers kept elsewhere
   function automatic logic [5:0] shp_ser_first(input logic [3:0] a);
      unique case (a)
         4'h6: return SHP_RAMP_CLK_HI_ADDR;
         4'h7: return SHP_POWER_DOWN_ADDR;
         4'h8: return SHP_I_GAIN_HI_ADDR;
         4'h9: return SHP_Q_GAIN_HI_ADDR;
         4'ha: return SHP_KEY_RAMP_ADDR;
         4'hb: return SHP_AUX_DAC_HI_ADDR;
         default: return 6'h00;
      endcase
   endfunction

   function automatic logic [2:0] shp_ser_count(input logic [3:0] a);
      unique case (a)
         4'h2, 4'h3, 4'h4: return 3'h6;
         4'h5, 4'h7: return 3'h4;
         4'h6: return 3'h3;
         4'h0, 4'h1, 4'h8, 4'h9, 4'hb: return 3'h2;
         default: return 3'h1;
      endcase
   endfunction

endpackage

/* File: design/shp_ser_if.sv */
// bundle between the serial controller and its bit shifter
interface shp_ser_if;
   logic rise;
   logic fall;
   logic sdi;
   logic lsb_first;
   logic abort;
   logic tx_load;
   logic [7:0] tx_load_byte;
   logic byte_done;
   logic [7:0] rx_byte;
   logic tx_bit;
   modport ctrl (output rise, fall, sdi, lsb_first, abort, tx_load, tx_load_byte,
      input byte_done, rx_byte, tx_bit);
   modport shift (input rise, fall, sdi, lsb_first, abort, tx_load, tx_load_byte,
      output byte_done, rx_byte, tx_bit);
endinterface

/* File: design/shp_ser_shift.sv */
// serial bit shifter: assembles bytes on rising and sends bits on falling clock
module shp_ser_shift (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   shp_ser_if.shift bus
);
   logic [2:0] cnt, next_cnt;
   logic [7:0] rx, next_rx;
   logic [7:0] tx, next_tx;
   logic done, next_done;
   logic txbit, next_txbit;

   always_comb begin
      next_cnt = cnt;
      next_rx = rx;
      next_tx = tx;
      next_done = 1'b0;
      next_txbit = txbit;
      if (bus.abort) begin
         next_cnt = 3'h0;
      end else if (bus.rise) begin
         next_rx = bus.lsb_first ? {bus.sdi, rx[7:1]} : {rx[6:0], bus.sdi};
         next_cnt = cnt + 3'h1;
         next_done = (cnt == 3'h7);
      end
      if (bus.tx_load) begin
         next_tx = bus.tx_load_byte;
      end else if (bus.fall) begin
         // data leaves on the falling clock edge
         next_txbit = bus.lsb_first ? tx[0] : tx[7];
         next_tx = bus.lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cnt <= 3'h0;
         rx <= 8'h00;
         tx <= 8'h00;
         done <= 1'b0;
         txbit <= 1'b0;
      end else begin
         cnt <= next_cnt;
         rx <= next_rx;
         tx <= next_tx;
         done <= next_done;
         txbit <= next_txbit;
      end
   end

   assign bus.byte_done = done;
   assign bus.rx_byte = rx;
   assign bus.tx_bit = txbit;
endmodule // shp_ser_shift

/* File: design/shp_sync.sv */
// two-flop synchroniser for a group of pin levels
module shp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         meta <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule // shp_sync

/* File: tb/shp_host_model.sv */
// host-side model driving the parallel and serial pins of the port
module shp_host_model (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe,
   input wire logic i_sdio,
   input wire logic i_sdio_oe,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic [5:0] o_addr,
   output logic [7:0] o_data,
   output logic o_wr_n,
   output logic o_rd_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] drv_a = 6'h00;
   logic [7:0] drv_d = 8'h00;
   // separate output line has a pull-up, so an undriven read shows ones
   logic three_wire = 1'b0;
   // ----------------------------------------------------------------
   // pin levels: device wins while it drives, else the host value
   // ----------------------------------------------------------------
   assign o_addr = {drv_a[5:1], i_sdio_oe ? i_sdio : drv_a[0]};
   assign o_data = i_data_oe ? i_data : drv_d;
   initial begin
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
   end
   // ----------------------------------------------------------------
   // parallel cycles
   // ----------------------------------------------------------------
   // strobe held 3 clocks each way, the port needs 2 to see a level
   task automatic par_write(input logic [5:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      drv_a = a;
      drv_d = d;
      o_wr_n = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      o_wr_n = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      drv_d = ~d;
   endtask
   // slow reads only, readback is a debug path
   task automatic par_read(input logic [5:0] a, output logic [7:0] d);
      @(negedge i_clk_sys);
      drv_a = a;
      o_rd_n = 1'b0;
      repeat (5) @(negedge i_clk_sys);
      d = o_data;
      o_rd_n = 1'b1;
      repeat (5) @(negedge i_clk_sys);
   endtask
   // ----------------------------------------------------------------
   // serial cycles, 80 ns clock, msb first, idle high between frames
   // ----------------------------------------------------------------
   task automatic ser_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         @(negedge i_clk_sys);
         drv_a[0] = tx[i];
         o_wr_n = 1'b0;
         repeat (10) @(negedge i_clk_sys);
         rx[i] = three_wire ? (i_sdo_oe ? i_sdo : 1'b1) : o_addr[0];
         o_wr_n = 1'b1;
         repeat (9) @(negedge i_clk_sys);
      end
      drv_a[0] = ~drv_a[0];
   endtask
   task automatic ser_xfer(input int junk, input logic [7:0] ins, input int n,
      input logic [31:0] wd, output logic [31:0] rd);
      logic [7:0] b;
      rd = 32'h0;
      @(negedge i_clk_sys);
      drv_a = 6'h00;
      o_rd_n = 1'b0;
      if (junk > 0) begin
         ser_bits(8'hff, junk, b);
         drv_a[2] = 1'b1;
         repeat (4) @(negedge i_clk_sys);
         drv_a[2] = 1'b0;
         repeat (4) @(negedge i_clk_sys);
      end
      ser_bits(ins, 8, b);
      for (int k = n - 1; k >= 0; k--) begin
         ser_bits(wd[8*k +: 8], 8, b);
         rd[8*k +: 8] = b;
      end
      @(negedge i_clk_sys);
      o_rd_n = 1'b1;
   endtask
endmodule // shp_host_model

/* File: tb/tb.sv */
// self-checking bench for the synth host port
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic port_sel = 1'b1;
   logic upd = 1'b0;
   logic reference_clock_input = 1'b0;
   logic [5:0] addr;
   logic [7:0] data;
   logic wr_n;
   logic rd_n;
   logic [7:0] o_data;
   logic data_oe;
   logic sdio;
   logic sdio_oe;
   logic serial_data_out_pin;
   logic sdo_oe;
   shp_pkg::shp_bank_t bank;
   int fail_count = 0;
   int num_checks = 0;
   logic [7:0] rst_val [14] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h64, 8'h01, 8'h20,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
   // bits that keep their value; ignored bits read zero
   logic [7:0] mask [14] = '{8'h0f, 8'hff, 8'hff, 8'h17, 8'h7f, 8'hff, 8'h73,
      8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff};
   always #2 clk_sys = ~clk_sys;
   shp_host_port DUT (.i_clk_sys(clk_sys), .i_reset(reset), .i_port_select(port_sel),
      .i_addr(addr), .i_data(data), .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n),
      .i_register_update_strobe(upd), .i_reference_clock_input(reference_clock_input), .o_data(o_data),
      .o_data_oe(data_oe), .o_serial_data_io(sdio), .o_serial_data_io_oe(sdio_oe),
      .o_serial_data_out_pin(serial_data_out_pin), .o_serial_data_out_pin_oe(sdo_oe), .o_active_bank(bank));
   shp_host_model host (.i_clk_sys(clk_sys), .i_data(o_data), .i_data_oe(data_oe),
      .i_sdio(sdio), .i_sdio_oe(sdio_oe), .i_sdo(serial_data_out_pin), .i_sdo_oe(sdo_oe), .o_addr(addr),
      .o_data(data), .o_wr_n(wr_n), .o_rd_n(rd_n));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic do_reset(input logic strap);
      @(negedge clk_sys);
      reset = 1'b1;
      port_sel = strap;
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [31:0] w;
      do_reset(1'b1);
      for (int k = 0; k < 14; k++) begin
         host.par_read(6'h1a + 6'(k), v);
         check("reset value", v, rst_val[k]);
      end
      host.par_write(6'h28, 8'hff);
      host.par_read(6'h28, v);
      check("unmapped read", v, 8'h00);
      // back to back writes of all ones, masked on readback
      for (int k = 0; k < 14; k++) begin
         host.par_write(6'h1a + 6'(k), 8'hff);
      end
      for (int k = 0; k < 14; k++) begin
         host.par_read(6'h1a + 6'(k), v);
         check("masked readback", v, mask[k]);
      end
      // default internal update copies staging within its period
      repeat (1100) @(negedge clk_sys);
      for (int k = 0; k < 14; k++) begin
         check("internal update", bank[k], mask[k]);
      end
      // external update chosen before the reference clock starts
      do_reset(1'b1);
      host.par_write(6'h1f, 8'h00);
      host.par_write(6'h25, 8'h5a);
      check("staged only", bank[11], 8'h80);
      reference_clock_input = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("reference start", bank[11], 8'h5a);
      check("mode byte", bank[5], 8'h00);
      host.par_write(6'h25, 8'h33);
      repeat (1100) @(negedge clk_sys);
      check("no internal update", bank[11], 8'h5a);
      upd = 1'b1;
      repeat (6) @(negedge clk_sys);
      upd = 1'b0;
      check("update strobe", bank[11], 8'h33);
      // serial port, one-wire default; external update set before the reference starts
      reference_clock_input = 1'b0;
      do_reset(1'b0);
      host.ser_xfer(0, 8'h07, 4, 32'h10640020, w);
      reference_clock_input = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("serial mode byte", bank[5], 8'h00);
      host.ser_xfer(0, 8'h87, 4, 32'h0, w);
      check("ctrl 1d", w[31:24], 8'h10);
      check("ctrl 1e", w[23:16], 8'h64);
      check("ctrl 1f", w[15:8], 8'h00);
      check("ctrl 20", w[7:0], 8'h20);
      host.ser_xfer(0, 8'h0a, 1, 32'hc3, w);
      host.ser_xfer(0, 8'h8a, 1, 32'h0, w);
      check("serial readback", w[7:0], 8'hc3);
      // minus one as a twelve-bit word; top nibble of the high byte is dropped
      host.ser_xfer(0, 8'h0b, 2, 32'hffff, w);
      host.ser_xfer(0, 8'h8b, 2, 32'h0, w);
      check("aux dac high", w[15:8], 8'h0f);
      check("aux dac low", w[7:0], 8'hff);
      // aborted partial instruction, next frame must still work
      host.ser_xfer(3, 8'h0a, 1, 32'h3c, w);
      host.ser_xfer(0, 8'h8a, 1, 32'h0, w);
      check("after sync reset", w[7:0], 8'h3c);
      // separate output pin, switched in by the update strobe
      host.ser_xfer(0, 8'h07, 4, 32'h10640021, w);
      upd = 1'b1;
      repeat (6) @(negedge clk_sys);
      upd = 1'b0;
      host.three_wire = 1'b1;
      host.ser_xfer(0, 8'h8a, 1, 32'h0, w);
      check("separate pin readback", w[7:0], 8'h3c);
      check("second pin idle", {7'h00, sdo_oe}, 8'h00);
      finish_test();
   end
   // hang guard, far beyond the few thousand clocks the run needs
   initial begin
      #200us;
      fail_count++;
      finish_test();
   end
endmodule // tb
